// ==== verilog/eiop_port.v ====
// Eight-bit I/O port with direction, comparator and reference muxing
`include "eiop_consts.vh"
module eiop_port
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] pin_in,
  output wire [7:0] pin_out,
  output wire [7:0] pin_oe,
  input wire cmp1_result,
  input wire cmp2_result,
  output wire timer_external_clock_in,
  output wire vref_enable,
  output wire vref_output_pin_en,
  output wire [3:0] vref_level,
  output wire vref_range,
  output wire [3:0] analog_input_sel
);
  reg [7:0] pin_direction_reg_r;
  reg [7:0] comparator_control_reg_r;
  reg [7:0] vref_control_reg_r;
  reg osc_claim_r;
  reg digin_on_r;
  wire [7:0] pin_data_latch_reg;
  wire acc;
  wire wr;
  wire rd_setup;
  wire wr_data_en;
  wire wr_dir_en;
  wire wr_cmp_en;
  wire wr_vref_en;
  wire wr_osc_en;
  reg hit_data;
  reg hit_dir;
  reg hit_cmp;
  reg hit_vref;
  reg hit_osc;
  wire hit_any;
  wire [2:0] cm;
  wire cmp_off;
  wire cmp_outs;
  wire [7:0] ana_in;
  wire [7:0] owned;
  wire [7:0] pin_read;
  wire [7:0] dir_eff;
  wire [7:0] drv_val;
  wire [7:0] oe_raw;
  wire [7:0] od_mask;
  wire [7:0] in_mask;
  wire [7:0] digin_mask;
  wire pin3_val;
  wire pin4_val;
  reg [31:0] rd_nxt;

  // One-hot mask of a single pin
  function [7:0] bit_mask;
    input integer idx;
    begin
      bit_mask = 8'h01 << idx;
    end
  endfunction

  // Byte register widened to the bus word
  function [31:0] rd_word;
    input [7:0] b;
    begin
      rd_word = {24'h000000, b};
    end
  endfunction

  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a[11:2] == off[9:0]) && (a[1:0] == 2'b00);
    end
  endfunction

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  // Read data latched in setup so it stands through access
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;

  always @*
  begin
    hit_data = 1'b0;
    hit_dir = 1'b0;
    hit_cmp = 1'b0;
    hit_vref = 1'b0;
    hit_osc = 1'b0;
    if (is_addr(paddr, `EIOP_OFF_DATA))
    begin
      hit_data = 1'b1;
    end
    else if (is_addr(paddr, `EIOP_OFF_DIR))
    begin
      hit_dir = 1'b1;
    end
    else if (is_addr(paddr, `EIOP_OFF_CMP))
    begin
      hit_cmp = 1'b1;
    end
    else if (is_addr(paddr, `EIOP_OFF_VREF))
    begin
      hit_vref = 1'b1;
    end
    else if (is_addr(paddr, `EIOP_OFF_OSC))
    begin
      hit_osc = 1'b1;
    end
  end

  assign hit_any = hit_data | hit_dir | hit_cmp | hit_vref | hit_osc;
  // Unmapped addresses answer with an error
  assign pslverr = acc && !hit_any;

  // One write strobe per register
  assign wr_data_en = wr && hit_data;
  assign wr_dir_en = wr && hit_dir;
  assign wr_cmp_en = wr && hit_cmp;
  assign wr_vref_en = wr && hit_vref;
  assign wr_osc_en = wr && hit_osc;
  // Fixed roles of the special pins
  assign od_mask = bit_mask(`EIOP_OD_PIN);
  assign in_mask = bit_mask(`EIOP_IN_PIN);

  assign cm = comparator_control_reg_r[`EIOP_CM_LSB+2:`EIOP_CM_LSB];
  assign cmp_off = (cm == `EIOP_CM_OFF);
  assign cmp_outs = (cm == `EIOP_CM_OUTS);
  // Every mode but off uses the low four pins as analog inputs
  assign ana_in = cmp_off ? 8'h00 : `EIOP_ANA_PINS;
  assign analog_input_sel = ana_in[3:0];

  assign owned = {osc_claim_r, osc_claim_r, 6'h00};

  assign digin_mask = digin_on_r ? 8'hff : ~`EIOP_ANA_PINS;
  assign pin_read = pin_in & ~ana_in & ~owned & digin_mask;

  assign dir_eff = pin_direction_reg_r | owned | in_mask;

  assign pin3_val = cmp_outs ? cmp1_result : pin_data_latch_reg[3];
  assign pin4_val = cmp_outs ? cmp2_result : pin_data_latch_reg[4];
  assign drv_val = {pin_data_latch_reg[7:5], pin4_val, pin3_val, pin_data_latch_reg[2:0]};

  assign oe_raw = ~dir_eff;
  assign pin_out = drv_val & ~od_mask;
  assign pin_oe = oe_raw & ~(od_mask & drv_val);
  assign timer_external_clock_in = pin_in[`EIOP_OD_PIN];

  assign vref_enable = vref_control_reg_r[7];
  assign vref_output_pin_en = vref_control_reg_r[`EIOP_VROE_BIT];
  assign vref_range = vref_control_reg_r[5];
  assign vref_level = vref_control_reg_r[3:0];

  eiop_latch u_latch
  (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_data_en),
    .wr_data(pwdata[7:0]),
    .pin_level(pin_read),
    .wr_mask(8'hff),
    .latch_r(pin_data_latch_reg)
  );

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_direction_reg_r <= `EIOP_DIR_RST;
    end
    else if (wr_dir_en)
    begin
      pin_direction_reg_r <= pwdata[7:0];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      comparator_control_reg_r <= `EIOP_CMP_RST;
    end
    else if (wr_cmp_en)
    begin
      comparator_control_reg_r <= pwdata[7:0];
    end
  end

  // Low digital inputs off until comparator setup
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      digin_on_r <= `EIOP_DIGIN_RST;
    end
    else if (wr_cmp_en)
    begin
      digin_on_r <= 1'b1;
    end
  end

  // Unused bit four is never stored
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vref_control_reg_r <= `EIOP_VREF_RST;
    end
    else if (wr_vref_en)
    begin
      vref_control_reg_r <= pwdata[7:0] & `EIOP_VREF_MASK;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_claim_r <= `EIOP_OSC_RST;
    end
    else if (wr_osc_en)
    begin
      osc_claim_r <= pwdata[0];
    end
  end

  // Read mux; unmapped addresses read zero
  always @*
  begin
    rd_nxt = `EIOP_PRDATA_RST;
    if (hit_data)
    begin
      rd_nxt = rd_word(pin_read);
    end
    else if (hit_dir)
    begin
      rd_nxt = rd_word(pin_direction_reg_r | in_mask);
    end
    else if (hit_cmp)
    begin
      rd_nxt = rd_word({cmp2_result, cmp1_result, comparator_control_reg_r[5:0]});
    end
    else if (hit_vref)
    begin
      rd_nxt = rd_word(vref_control_reg_r);
    end
    else if (hit_osc)
    begin
      rd_nxt = rd_word({7'h00, osc_claim_r});
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= `EIOP_PRDATA_RST;
    end
    else if (rd_setup)
    begin
      prdata <= rd_nxt;
    end
  end
endmodule // eiop_port

// ==== verilog/eiop_consts.vh ====
// Register offsets, fields and reset values of the eight-bit port
`ifndef EIOP_CONSTS_VH
`define EIOP_CONSTS_VH
`define EIOP_OFF_DATA 12'h005
`define EIOP_OFF_DIR 12'h085
`define EIOP_OFF_CMP 12'h01f
`define EIOP_OFF_VREF 12'h09f
`define EIOP_OFF_OSC 12'h100
`define EIOP_DIR_RST 8'hff
`define EIOP_CMP_RST 8'h00
`define EIOP_VREF_RST 8'h00
`define EIOP_VREF_MASK 8'hef
`define EIOP_OSC_RST 1'b0
`define EIOP_LATCH_RST 8'h00
`define EIOP_DIGIN_RST 1'b0
`define EIOP_PRDATA_RST 32'h00000000
`define EIOP_CM_OFF 3'h7
`define EIOP_CM_OUTS 3'h6
`define EIOP_CM_LSB 0
`define EIOP_VROE_BIT 6
`define EIOP_OD_PIN 4
`define EIOP_IN_PIN 5
`define EIOP_VREF_PIN 2
`define EIOP_CMP1_PIN 3
`define EIOP_ANA_PINS 8'h0f
`endif

// ==== verilog/eiop_latch.v ====
// Output data latch with read-modify-write merge
`include "eiop_consts.vh"
module eiop_latch
(
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire [7:0] pin_level,
  input wire [7:0] wr_mask,
  output reg [7:0] latch_r
);
  wire [7:0] latch_nxt;
  assign latch_nxt = (pin_level & ~wr_mask) | (wr_data & wr_mask);
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latch_r <= `EIOP_LATCH_RST;
    else if (wr_en)
      latch_r <= latch_nxt;
  end
endmodule // eiop_latch

// ==== verif/eiop_props.sv ====
// Assertion checker for the eight-bit port
module eiop_props (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic timer_external_clock_in,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic [7:0] pin_in,
  input logic [7:0] pin_oe,
  input logic [7:0] pin_out,
  input logic [3:0] analog_input_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rd_data;
    psel && !penable && !pwrite && paddr == 12'h014;
  endsequence
  sequence wr_at(a);
    psel && penable && pwrite && paddr == a;
  endsequence
  a_od_low_only: assert property (pin_oe[4] |-> !pin_out[4]) else $error("od high");
  a_tclk_follows: assert property (timer_external_clock_in == pin_in[4]) else $error("tclk");
  a_in_never_drv: assert property (!pin_oe[5]) else $error("in pin driven");
  a_dir_hiz: assert property (wr_at(12'h214) ##0 pwdata[1] |=> !pin_oe[1])
    else $error("dir 1 drives");
  a_dir_drive: assert property (wr_at(12'h214) ##0 !pwdata[1] |=> pin_oe[1])
    else $error("dir 0 idle");
  a_latch_out: assert property (wr_at(12'h014) |=> pin_out[1] == $past(pwdata[1]))
    else $error("latch");
  a_rst_inputs: assert property ($rose(presetn) |-> pin_oe == 8'h00) else $error("rst oe");
  a_ana_zero: assert property (rd_data ##0 analog_input_sel[0] |=> !prdata[0])
    else $error("analog read");
  a_cmp_free: assert property (wr_at(12'h07c) ##0 pwdata[2:0] == 3'h7 |=> !analog_input_sel)
    else $error("cmp off");
  a_osc_undriven: assert property (wr_at(12'h400) ##0 pwdata[0] |=> pin_oe[7:6] == 2'b00)
    else $error("claimed pin driven");
endmodule // eiop_props
bind eiop_port eiop_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .timer_external_clock_in(timer_external_clock_in), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pin_in(pin_in), .pin_oe(pin_oe), .pin_out(pin_out),
  .analog_input_sel(analog_input_sel));

// ==== verif/eiop_board.sv ====
// Board model driving the port pins
module eiop_board (
  input logic [7:0] pin_out,
  input logic [7:0] pin_oe,
  input logic [7:0] ext_val,
  input logic [7:0] ext_en,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  always_comb
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : 1'b1;
endmodule // eiop_board

// ==== verif/tb_top.sv ====
// Self-checking bench for the eight-bit port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0] pin_in, pin_out, pin_oe, ext_val = 0, ext_en = 0;
  logic cmp1 = 0, cmp2 = 0, vref_en, vref_oe, vref_rng;
  logic [3:0] vref_lvl;
  int miscompares = 0, n_checks = 0;
  initial forever #5 pclk = ~pclk;
  eiop_port i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .cmp1_result(cmp1), .cmp2_result(cmp2), .timer_external_clock_in(), .vref_enable(vref_en),
    .vref_output_pin_en(vref_oe), .vref_level(vref_lvl), .vref_range(vref_rng),
    .analog_input_sel());
  eiop_board i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(ext_en), .pin_in(pin_in));
  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
    int n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (!w) chk({pslverr, prdata}, e);
    psel <= 0;
    penable <= 0;
    if (n >= 50)
    begin
      miscompares++;
      print_verdict();
    end
  endtask
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h214, 0, 8'hff);
    apb(0, 12'h014, 0, 8'hf0);
    apb(1, 12'h07c, 8'h07, 0);
    apb(0, 12'h014, 0, 8'hff);
    apb(1, 12'h014, 8'ha5, 0);
    apb(1, 12'h214, 8'h00, 0);
    apb(0, 12'h214, 0, 8'h20);
    apb(0, 12'h014, 0, 8'ha5);
    chk({25'h0, pin_oe}, 8'hdf);
    apb(1, 12'h014, 8'h5a, 0);
    apb(0, 12'h014, 0, 8'h7a);
    apb(1, 12'h400, 8'h01, 0);
    apb(0, 12'h014, 0, 8'h3a);
    chk({25'h0, pin_oe}, 8'h0f);
    ext_val <= 8'h3c;
    ext_en <= 8'hff;
    apb(1, 12'h214, 8'hff, 0);
    apb(0, 12'h014, 0, 8'h3c);
    apb(1, 12'h07c, 8'h00, 0);
    apb(0, 12'h014, 0, 8'h30);
    apb(1, 12'h07c, 8'h06, 0);
    cmp1 <= 1;
    apb(1, 12'h214, 8'he7, 0);
    apb(0, 12'h07c, 0, 8'h46);
    chk({25'h0, pin_oe}, 8'h18);
    chk({25'h0, pin_out}, 8'h4a);
    cmp2 <= 1;
    @(posedge pclk);
    chk({25'h0, pin_oe}, 8'h08);
    apb(1, 12'h214, 8'hff, 0);
    apb(1, 12'h27c, 8'hff, 0);
    apb(0, 12'h27c, 0, 8'hef);
    chk({25'h0, pin_oe}, 8'h00);
    chk({25'h0, vref_en, vref_oe, vref_rng, 1'b0, vref_lvl}, 8'hef);
    apb(0, 12'h008, 0, 33'h100000000);
    print_verdict();
  end
endmodule // tb_top
